// ---- hw/led_startup_cfg.svh ----
/*
  Offsets, field positions, reset values and timing counts for the LED
  driver start-up, power-on-reset and serial latch logic.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LED_STARTUP_CFG_SVH
`define LED_STARTUP_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CHAN_SEL 12'h008
`define OFS_CHAN_DATA 12'h00C
`define OFS_DIM_COUNT 12'h010

// ----------------------------------------------------------------------
// Fields and layout
// ----------------------------------------------------------------------
`define CTRL_RESTART_BIT 0
`define CHAIN_LEN 194
`define CHAN_COUNT 16
`define GS_WIDTH 12
`define DC_WIDTH 6
`define CMD_FRAME_KIND_POS 192
`define CMD_LIGHT_ENABLE_POS 193
`define GS_RESET 12'h000
`define DC_RESET 6'h00
`define DIM_PERIOD 4096

`endif

// ---- hw/led_startup_pkg.sv ----
/*
  Types shared by the start-up and power-on-reset logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package led_startup_pkg;

  // Power sequencing states
  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_LOCKOUT = 2'b01,
    ST_SOFT_START = 2'b10,
    ST_RUN = 2'b11
  } power_state_t;

endpackage

`default_nettype wire

// ---- hw/pin_sync.sv ----
/*
  Three-flop synchroniser for pins from another domain. The output
  changes only once the second and third flop agree.
  Assumes an asynchronous active-low reset in the receiving domain.
*/
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          level[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          level[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- hw/por_release.sv ----
/*
  Power-on-reset generator: asserts at once, releases on the clock.
  Assumes run_ok comes from a flop in the same clock domain.
*/
`default_nettype none

module por_release (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_ok,
  output logic por_n
);

  logic hold_reg;
  logic arm_n;

  // Dropping run_ok clears the chain at once, without a clock edge
  assign arm_n = rst_n & run_ok;

  always_ff @(posedge clk or negedge arm_n) begin
    if (!arm_n) begin
      hold_reg <= 1'b0;
      por_n <= 1'b0;
    end else begin
      hold_reg <= 1'b1;
      por_n <= hold_reg;
    end
  end

endmodule

`default_nettype wire

// ---- hw/led_startup_por.sv ----
/*
  Start-up sequencing, power-on-reset, latched settings, serial shift
  chain and grayscale dimming for a sixteen-channel LED driver.
  Assumes the analog comparators deliver digital flags on pins, an APB
  master on pclk, and a host shifting data on its own shift clock.
*/
// Decided for this implementation: the APB register port and the address map.
// Functional notes
// - Below the wake threshold the chip sits in shutdown, bias off.
// - Any of the three lockout flags keeps the chip in lockout.
// - With all lockout flags clear, switching and soft-start start.
// - During power-on-reset serial inputs are ignored, the chain kept.
// - Power-on-reset clears frame select, lamp-on, grayscale and dot.
// - After reset all channels are off with zero settings.
// - Reset releases only after soft-start done and power good.
// - A fault restarting soft-start reasserts reset and clears again.
// - A latch pulse moves the chain into settings and loads status.
// - Each channel compares a dimming count with its grayscale value.
// - Data shifts into the chain bottom; the top drives the output.
// - Command bit 0 picks frame kind, command bit 1 lights channels.
// - A latch updates command bits and, in the same cycle, grayscale or dot settings.
// - A dimming period is a fixed count; all channels rise together.
`default_nettype none
`include "led_startup_cfg.svh"

module led_startup_por #(
  parameter int CHANNELS = `CHAN_COUNT,
  parameter int CHAIN = `CHAIN_LEN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_wake_input,
  input wire logic [2:0] undervoltage_lockout,
  input wire logic soft_start_done,
  input wire logic power_good,
  input wire logic fault_restart,
  input wire logic over_temp,
  input wire logic [15:0] led_fault,
  output logic bias_enable,
  output logic buck_switch_enable,
  output logic soft_start_release,
  output logic por_active,
  input wire logic shift_clock_in,
  input wire logic serial_data_in,
  input wire logic latch_in,
  output logic shift_clock_out,
  output logic serial_data_out,
  output logic latch_out,
  input wire logic dimming_count_clock,
  output logic [15:0] led_on
);
  import led_startup_pkg::*;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  localparam int NPIN = 26;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] pins_s;
  logic wake_s;
  logic [2:0] undervoltage_lockout_s;
  logic ss_done_s;
  logic pgood_s;
  logic fault_s;
  logic ot_s;
  logic [15:0] lfault_s;
  logic latch_s;
  logic dimclk_s;

  assign pins = {dimming_count_clock, latch_in, led_fault, over_temp,
                 fault_restart, power_good, soft_start_done,
                 undervoltage_lockout, chip_wake_input};

  pin_sync #(.WIDTH(NPIN)) u_pins (
    .clk(pclk),
    .rst_n(presetn),
    .pin(pins),
    .level(pins_s)
  );

  assign wake_s = pins_s[0];
  assign undervoltage_lockout_s = pins_s[3:1];
  assign ss_done_s = pins_s[4];
  assign pgood_s = pins_s[5];
  assign fault_s = pins_s[6];
  assign ot_s = pins_s[7];
  assign lfault_s = pins_s[23:8];
  assign latch_s = pins_s[24];
  assign dimclk_s = pins_s[25];

  // --------------------------------------------------------------------
  // Power sequencing
  // --------------------------------------------------------------------
  power_state_t state_reg;
  power_state_t state_next;
  logic restart_req_reg;
  logic run_ok_reg;
  logic por_n;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUTDOWN: begin
        if (wake_s) begin
          state_next = ST_LOCKOUT;
        end
      end
      ST_LOCKOUT: begin
        if (!wake_s) begin
          state_next = ST_SHUTDOWN;
        end else if (undervoltage_lockout_s == 3'b000) begin
          state_next = ST_SOFT_START;
        end
      end
      ST_SOFT_START: begin
        if (!wake_s) begin
          state_next = ST_SHUTDOWN;
        end else if (undervoltage_lockout_s != 3'b000) begin
          state_next = ST_LOCKOUT;
        end else if (ss_done_s && pgood_s && !fault_s) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!wake_s) begin
          state_next = ST_SHUTDOWN;
        end else if (undervoltage_lockout_s != 3'b000) begin
          state_next = ST_LOCKOUT;
        end else if (fault_s || restart_req_reg) begin
          state_next = ST_SOFT_START;
        end
      end
      default: state_next = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_SHUTDOWN;
      run_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_ok_reg <= (state_next == ST_RUN);
    end
  end

  // Leaving RUN drops run_ok, which clears the settings asynchronously
  por_release u_por (
    .clk(pclk),
    .rst_n(presetn),
    .run_ok(run_ok_reg),
    .por_n(por_n)
  );

  assign bias_enable = (state_reg != ST_SHUTDOWN);
  assign buck_switch_enable = state_reg[1];
  assign soft_start_release = state_reg[1];
  assign por_active = ~por_n;

  // --------------------------------------------------------------------
  // Settings latched from the chain
  // --------------------------------------------------------------------
  logic [CHAIN-1:0] chain_reg;
  logic latch_d_reg;
  logic latch_evt;
  logic frame_select_reg;
  logic lamp_on_reg;
  logic [`GS_WIDTH-1:0] grayscale_level_reg [CHANNELS];
  logic [`DC_WIDTH-1:0] dot_correction_reg [CHANNELS];
  // Nets: the per-channel slices are driven by separate assignments
  wire logic [CHAIN-1:0] status_word_reg;
  logic load_tgl_reg;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      latch_d_reg <= 1'b0;
    end else begin
      latch_d_reg <= latch_s;
    end
  end

  // Latch edges are ignored while reset holds (latch_evt gated by por_n)
  assign latch_evt = latch_s & ~latch_d_reg & por_n;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      frame_select_reg <= 1'b0;
      lamp_on_reg <= 1'b0;
    end else if (latch_evt) begin
      frame_select_reg <= chain_reg[`CMD_FRAME_KIND_POS];
      lamp_on_reg <= chain_reg[`CMD_LIGHT_ENABLE_POS];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_set
      always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
          grayscale_level_reg[ch] <= `GS_RESET;
          dot_correction_reg[ch] <= `DC_RESET;
        end else if (latch_evt) begin
          // Chain is still while the host holds its clock after a latch
          if (!chain_reg[`CMD_FRAME_KIND_POS]) begin
            grayscale_level_reg[ch] <=
              chain_reg[ch*`GS_WIDTH +: `GS_WIDTH];
          end else begin
            dot_correction_reg[ch] <=
              chain_reg[ch*`GS_WIDTH +: `DC_WIDTH];
          end
        end
      end
      assign status_word_reg[ch*`GS_WIDTH +: `GS_WIDTH] =
        {6'h00, dot_correction_reg[ch]};
    end
  endgenerate

  // Flags are frozen at the latch so the link reads a steady word
  logic [15:0] fault_cap_reg;
  logic ot_cap_reg;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      load_tgl_reg <= 1'b0;
      fault_cap_reg <= 16'h0000;
      ot_cap_reg <= 1'b0;
    end else if (latch_evt) begin
      load_tgl_reg <= ~load_tgl_reg;
      fault_cap_reg <= lfault_s;
      ot_cap_reg <= ot_s;
    end
  end

  // Status fields sit in the command area, above the channel data
  assign status_word_reg[CHAIN-1 -: 2] = {ot_cap_reg, 1'b0};

  // --------------------------------------------------------------------
  // Link side: shift chain on the host's shift clock
  // --------------------------------------------------------------------
  logic por_l1_reg;
  logic por_l2_reg;
  logic tgl_l1_reg;
  logic tgl_l2_reg;
  logic tgl_seen_reg;
  wire logic [CHAIN-1:0] load_word;

  // Each fault flag takes the lowest spare bit above its dot value
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_load
      assign load_word[ch*`GS_WIDTH +: `GS_WIDTH] =
        {5'h00, fault_cap_reg[ch],
         status_word_reg[ch*`GS_WIDTH +: `DC_WIDTH]};
    end
  endgenerate
  assign load_word[CHAIN-1 -: 2] = status_word_reg[CHAIN-1 -: 2];

  always_ff @(posedge shift_clock_in or negedge presetn) begin
    if (!presetn) begin
      por_l1_reg <= 1'b1;
      por_l2_reg <= 1'b1;
      tgl_l1_reg <= 1'b0;
      tgl_l2_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      por_l1_reg <= ~por_n;
      por_l2_reg <= por_l1_reg;
      tgl_l1_reg <= load_tgl_reg;
      tgl_l2_reg <= tgl_l1_reg;
      tgl_seen_reg <= tgl_l2_reg;
    end
  end

  // Chain is cleared only at power-up; reset of settings leaves it alone
  always_ff @(posedge shift_clock_in or negedge presetn) begin
    if (!presetn) begin
      chain_reg <= '0;
    end else if (por_l2_reg) begin
      chain_reg <= chain_reg;
    end else if (tgl_l2_reg != tgl_seen_reg) begin
      // Whole-word load so the top status bit is shown first;
      // the data bit offered on this edge is dropped
      chain_reg <= load_word;
    end else begin
      chain_reg <= {chain_reg[CHAIN-2:0], serial_data_in};
    end
  end

  assign serial_data_out = chain_reg[CHAIN-1];
  // Forwarded strobes: gated off while reset blocks the interface
  assign shift_clock_out = shift_clock_in & por_n;
  assign latch_out = latch_in & por_n;

  // --------------------------------------------------------------------
  // Grayscale dimming
  // --------------------------------------------------------------------
  logic [`GS_WIDTH-1:0] dim_count_reg;
  logic dimclk_d_reg;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      dim_count_reg <= '0;
      dimclk_d_reg <= 1'b0;
    end else begin
      dimclk_d_reg <= dimclk_s;
      if (dimclk_s && !dimclk_d_reg) begin
        // Natural wrap of the 12-bit count gives the fixed period
        dim_count_reg <= dim_count_reg + 12'h001;
      end
    end
  end

  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_dim
      always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
          led_on[ch] <= 1'b0;
        end else begin
          led_on[ch] <= lamp_on_reg &
            (dim_count_reg < grayscale_level_reg[ch]);
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // APB slave, zero wait states
  // --------------------------------------------------------------------
  logic [3:0] chan_sel_reg;
  logic wr_en;
  logic rd_hit;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_sel_reg <= 4'h0;
      restart_req_reg <= 1'b0;
    end else begin
      if (wr_en && paddr == `OFS_CHAN_SEL) begin
        chan_sel_reg <= pwdata[3:0];
      end
      // Request stands until the sequencer leaves RUN
      if (state_reg != ST_RUN) begin
        restart_req_reg <= 1'b0;
      end else if (wr_en && paddr == `OFS_CTRL &&
                   pwdata[`CTRL_RESTART_BIT]) begin
        restart_req_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == `OFS_CTRL) begin
      prdata = {31'h0000_0000, restart_req_reg};
    end else if (paddr == `OFS_STATUS) begin
      prdata = {23'h00_0000, undervoltage_lockout_s, ot_s, lamp_on_reg, frame_select_reg,
                ~por_n, state_reg};
    end else if (paddr == `OFS_CHAN_SEL) begin
      prdata = {28'h000_0000, chan_sel_reg};
    end else if (paddr == `OFS_CHAN_DATA) begin
      prdata = {10'h000, dot_correction_reg[chan_sel_reg], 4'h0,
                grayscale_level_reg[chan_sel_reg]};
    end else if (paddr == `OFS_DIM_COUNT) begin
      prdata = {20'h0_0000, dim_count_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~rd_hit;

endmodule

`default_nettype wire

// ---- verif/led_startup_por_properties.sv ----
/*
  Port-level checks on power sequencing, reset and output gating.
  Assumes binding to led_startup_por; pins settle within seven edges.
*/
`default_nettype none
module led_startup_por_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] undervoltage_lockout,
  input wire logic soft_start_done,
  input wire logic power_good,
  input wire logic fault_restart,
  input wire logic bias_enable,
  input wire logic buck_switch_enable,
  input wire logic soft_start_release,
  input wire logic por_active,
  input wire logic shift_clock_out,
  input wire logic latch_out,
  input wire logic [15:0] led_on
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Edges a condition has stood at the pins; saturates past the
  // synchroniser and state latency
  logic [2:0] uv_cnt;
  logic [2:0] bad_cnt;
  logic bad;
  assign bad = !power_good || !soft_start_done || fault_restart;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uv_cnt <= 3'h0;
    else if (undervoltage_lockout == 3'b000) uv_cnt <= 3'h0;
    else if (uv_cnt != 3'h7) uv_cnt <= uv_cnt + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bad_cnt <= 3'h0;
    else if (!bad) bad_cnt <= 3'h0;
    else if (bad_cnt != 3'h7) bad_cnt <= bad_cnt + 3'h1;
  end
  chk_bias_with_buck: assert property (
    buck_switch_enable |-> bias_enable) else $error("switching, no bias");
  chk_lockout_stops_buck: assert property (
    uv_cnt == 3'h7 |-> !buck_switch_enable && !soft_start_release)
    else $error("buck running in lockout");
  chk_buck_and_ss: assert property (
    buck_switch_enable == soft_start_release)
    else $error("buck and soft-start disagree");
  chk_por_until_run: assert property (
    !soft_start_release |-> por_active) else $error("reset left early");
  chk_por_when_bad: assert property (
    bad_cnt == 3'h7 |-> por_active) else $error("reset not held");
  chk_release_cause: assert property (
    $fell(por_active) |-> soft_start_release && $past(power_good, 4)
      && $past(soft_start_done, 4)) else $error("release without cause");
  chk_dark_in_por: assert property (
    por_active && $past(por_active, 2) |-> led_on == 16'h0000)
    else $error("channel lit in reset");
  chk_link_gated: assert property (
    por_active && $past(por_active, 4) |-> !latch_out && !shift_clock_out)
    else $error("link passed in reset");
endmodule
`default_nettype wire

// ---- verif/link_host_model.sv ----
/*
  Host on the serial link: makes its own shift clock, data and latch.
  Assumes the clock stands low between frames.
*/
`default_nettype none
module link_host_model (
  output logic shift_clock_in,
  output logic serial_data_in,
  output logic latch_in,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    shift_clock_in = 1'b0;
    serial_data_in = 1'b0;
    latch_in = 1'b0;
  end
  // Three lead-in edges: two cross the status load, the third loads it
  task automatic send_frame(input logic [193:0] frame,
                            output logic [193:0] rx);
    logic [196:0] bits;
    bits = {3'b000, frame};
    rx = '0;
    for (int i = 196; i >= 0; i--) begin
      serial_data_in = bits[i];
      // Output is taken as it stands before the rising edge
      rx = {rx[192:0], serial_data_out};
      #24 shift_clock_in = 1'b1;
      #24 shift_clock_in = 1'b0;
    end
    // Idle data must not look like the last bit
    serial_data_in = ~serial_data_in;
    // Pulse spans several system clocks so the pin filter keeps it
    #24 latch_in = 1'b1;
    #200 latch_in = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

// ---- verif/led_startup_por_tb.sv ----
/*
  Self-checking bench for the start-up and power-on-reset block.
  Assumes hw/ on the include path.
*/
`default_nettype none
`include "led_startup_cfg.svh"
module led_startup_por_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic chip_wake_input, soft_start_done, power_good, fault_restart;
  logic over_temp, bias_enable, buck_switch_enable, soft_start_release;
  logic por_active, shift_clock_in, serial_data_in, latch_in;
  logic shift_clock_out, serial_data_out, latch_out, dimming_count_clock;
  logic [2:0] undervoltage_lockout;
  logic [15:0] led_fault, led_on;
  logic [193:0] rx;
  int fail_count, n_checks, cyc;
  led_startup_por DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .chip_wake_input,
    .undervoltage_lockout, .soft_start_done, .power_good, .fault_restart,
    .over_temp, .led_fault, .bias_enable, .buck_switch_enable,
    .soft_start_release, .por_active, .shift_clock_in, .serial_data_in,
    .latch_in, .shift_clock_out, .serial_data_out, .latch_out,
    .dimming_count_clock, .led_on);
  link_host_model host (.shift_clock_in, .serial_data_in, .latch_in,
    .serial_data_out);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [193:0] seen, input logic [193:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic status(input logic [31:0] exp);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(v & 32'h0000_01FF, exp);
  endtask
  task automatic wait_por(input logic lvl);
    for (int i = 0; i < 40 && por_active !== lvl; i++)
      @(posedge pclk);
    chk(por_active, lvl);
  endtask
  // m[0]: dot values loaded, m[1]: grayscale values loaded
  task automatic chans(input logic [1:0] m);
    for (int n = 0; n < 16; n++) begin
      apb(1'b1, `OFS_CHAN_SEL, 32'(n));
      apb(1'b0, `OFS_CHAN_DATA, 32'h0000_0000);
      chk(v, {10'h000, m[0] ? 6'(n + 32) : 6'h00, 4'h0,
        m[1] ? 12'(n) : 12'h000});
    end
  endtask
  function automatic logic [193:0] mk(input logic kind);
    logic [193:0] fr;
    fr = '0;
    fr[193] = 1'b1;
    fr[192] = kind;
    for (int n = 0; n < 16; n++)
      fr[12*n +: 12] = kind ? 12'(n + 32) : 12'(n);
    return fr;
  endfunction
  function automatic logic [193:0] st();
    logic [193:0] fr;
    fr = '0;
    fr[193] = over_temp;
    for (int n = 0; n < 16; n++) begin
      fr[12*n + 6] = led_fault[n];
      fr[12*n +: 6] = 6'(n + 32);
    end
    return fr;
  endfunction
  task automatic pulse(input int n);
    repeat (n) begin
      dimming_count_clock <= 1'b1;
      ticks(3);
      dimming_count_clock <= 1'b0;
      ticks(3);
    end
    ticks(8);
  endtask
  task automatic t_shutdown();
    ticks(10);
    chk(bias_enable, 1'b0);
    status(32'h0000_0004);
  endtask
  task automatic t_lockout();
    chip_wake_input <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      undervoltage_lockout <= 3'(1 << i);
      ticks(10);
      chk(bias_enable, 1'b1);
      chk(buck_switch_enable, 1'b0);
      status(32'h0000_0005 | (32'h0000_0040 << i));
    end
  endtask
  task automatic t_ramp();
    undervoltage_lockout <= 3'b000;
    ticks(10);
    chk(soft_start_release, 1'b1);
    chk(por_active, 1'b1);
    soft_start_done <= 1'b1;
    ticks(10);
    chk(por_active, 1'b1);
    power_good <= 1'b1;
    wait_por(1'b0);
    status(32'h0000_0003);
  endtask
  task automatic t_frames();
    over_temp <= 1'b1;
    led_fault <= 16'hA5C3;
    host.send_frame(mk(1'b1), rx);
    chans(2'b01);
    status(32'h0000_003B);
    host.send_frame(mk(1'b0), rx);
    chk(rx, st());
    chans(2'b11);
    status(32'h0000_0033);
  endtask
  task automatic t_dimming();
    pulse(5);
    apb(1'b0, `OFS_DIM_COUNT, 32'h0000_0000);
    chk(v, 32'h0000_0005);
    chk(led_on, 16'hFFC0);
    pulse(4091);
    chk(led_on, 16'hFFFE);
  endtask
  task automatic t_fault();
    fault_restart <= 1'b1;
    wait_por(1'b1);
    ticks(2);
    chk(led_on, 16'h0000);
    host.send_frame(mk(1'b1), rx);
    fault_restart <= 1'b0;
    wait_por(1'b0);
    chans(2'b00);
    status(32'h0000_0023);
  endtask
  task automatic t_restart();
    host.send_frame(mk(1'b0), rx);
    status(32'h0000_0033);
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    wait_por(1'b1);
    wait_por(1'b0);
    status(32'h0000_0023);
  endtask
  task automatic t_unmapped();
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({err, v}, {1'b1, 32'h0000_0000});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 26000 cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    chip_wake_input = 1'b0;
    undervoltage_lockout = 3'b000;
    soft_start_done = 1'b0;
    power_good = 1'b0;
    fault_restart = 1'b0;
    over_temp = 1'b0;
    led_fault = 16'h0000;
    dimming_count_clock = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_shutdown();
    t_lockout();
    t_ramp();
    t_frames();
    t_dimming();
    t_fault();
    t_restart();
    t_unmapped();
    test_done();
  end
endmodule
bind led_startup_por led_startup_por_properties u_props (.pclk, .presetn,
  .undervoltage_lockout, .soft_start_done, .power_good, .fault_restart,
  .bias_enable, .buck_switch_enable, .soft_start_release, .por_active,
  .shift_clock_out, .latch_out, .led_on);
`default_nettype wire
